// [letmr_consts.vh]
`ifndef LETMR_CONSTS_VH
`define LETMR_CONSTS_VH

// Register byte offsets
`define LETMR_OFF_CTRL     8'h00
`define LETMR_OFF_CMD      8'h04
`define LETMR_OFF_STATUS   8'h08
`define LETMR_OFF_CNT      8'h0C
`define LETMR_OFF_COMPARE_ZERO_FLAG    8'h10
`define LETMR_OFF_COMPARE_ONE_FLAG    8'h14
`define LETMR_OFF_REPEAT_ZERO_FLAG     8'h18
`define LETMR_OFF_REPEAT_ONE_FLAG     8'h1C
`define LETMR_OFF_IF       8'h20
`define LETMR_OFF_IEN      8'h24

// Control fields
`define LETMR_CTRL_CTOP    0
`define LETMR_CTRL_BTOP    1
`define LETMR_CTRL_RM_LO   2
`define LETMR_CTRL_RM_HI   3

// Command bits
`define LETMR_CMD_START    0
`define LETMR_CMD_STOP     1
`define LETMR_CMD_CLEAR    2

// Flag bit positions
`define LETMR_IF_COMPARE_ZERO_FLAG     0
`define LETMR_IF_COMPARE_ONE_FLAG     1
`define LETMR_IF_UF        2
`define LETMR_IF_REPEAT_ZERO_FLAG      3
`define LETMR_IF_REPEAT_ONE_FLAG      4
`define LETMR_NFLAGS       5

// Repeat mode encodings
`define LETMR_RM_FREE      2'h0
`define LETMR_RM_ONESHOT   2'h1
`define LETMR_RM_BUFFERED  2'h2
`define LETMR_RM_DOUBLE    2'h3

// Widths and reset values
`define LETMR_CW           16
`define LETMR_RW           8
`define LETMR_WRAP_TOP     16'hFFFF
`define LETMR_RST_CNT      16'h0000
`define LETMR_RST_COMP     16'h0000
`define LETMR_RST_REP      8'h00

`endif

// [letmr_sticky_flag.v]
`timescale 1ns/10ps
`default_nettype none

module letmr_sticky_flag (
    // Clock and reset
    input  wire clock,
    input  wire srst,
    // Event and clear
    input  wire set_pulse,
    input  wire clr_pulse,
    // Flag
    output reg  flag
);

    // Set beats clear so a coincident event is never lost
    always @(posedge clock) begin
        if (srst) begin
            flag <= 1'b0;
        end else if (set_pulse) begin
            flag <= 1'b1;
        end else if (clr_pulse) begin
            flag <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// [letmr_repeat_counter.v]
`timescale 1ns/10ps
`default_nettype none
`include "letmr_consts.vh"

module letmr_repeat_counter (
    // Clock and reset
    input  wire                    clock,
    input  wire                    srst,
    // Software write
    input  wire                    sw_wr,
    input  wire [`LETMR_RW-1:0]    sw_data,
    // Hardware reload and decrement
    input  wire                    hw_load,
    input  wire [`LETMR_RW-1:0]    hw_data,
    input  wire                    hw_dec,
    // Count
    output reg  [`LETMR_RW-1:0]    value
);

    // Software wins; a counter at zero stays at zero
    always @(posedge clock) begin
        if (srst) begin
            value <= `LETMR_RST_REP;
        end else if (sw_wr) begin
            value <= sw_data;
        end else if (hw_load) begin
            value <= hw_data;
        end else if (hw_dec && value != `LETMR_RST_REP) begin
            value <= value - 8'h01;
        end
    end

endmodule

`default_nettype wire

// [letmr_timer.v]
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "letmr_consts.vh"

module letmr_timer (
    // Clock and reset
    input  wire        clock,
    input  wire        srst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // Interrupt and status
    output wire        irq,
    output wire        running_out
);

    // Software-visible state
    reg  [3:0]                 timer_control;
    reg  [`LETMR_CW-1:0]       timer_counter_value;
    reg  [`LETMR_CW-1:0]       compare_reg_zero;
    reg  [`LETMR_CW-1:0]       compare_reg_one;
    reg  [`LETMR_NFLAGS-1:0]   irq_enable;
    reg                        running;
    reg                        repeat_one_flag_written;
    wire [`LETMR_RW-1:0]       repeat_count_zero;
    wire [`LETMR_RW-1:0]       repeat_count_one;
    wire [`LETMR_NFLAGS-1:0]   timer_irq_flags;

    // Control fields
    wire       compare_as_top_en = timer_control[`LETMR_CTRL_CTOP];
    wire       buffered_top_en   = timer_control[`LETMR_CTRL_BTOP];
    wire [1:0] repeat_mode_sel   = timer_control[`LETMR_CTRL_RM_HI:`LETMR_CTRL_RM_LO];

    // Decoded repeat modes that need their own hardware
    wire       mode_buffered     = (repeat_mode_sel == `LETMR_RM_BUFFERED);
    wire       mode_double       = (repeat_mode_sel == `LETMR_RM_DOUBLE);

    // Bus decode; zero wait states, so every access ends in one access cycle
    wire bus_wr = psel & penable & pwrite;
    wire bus_rd = psel & ~penable & ~pwrite;
    wire mapped = (paddr == `LETMR_OFF_CTRL)  | (paddr == `LETMR_OFF_CMD)   |
                  (paddr == `LETMR_OFF_STATUS) | (paddr == `LETMR_OFF_CNT)  |
                  (paddr == `LETMR_OFF_COMPARE_ZERO_FLAG) | (paddr == `LETMR_OFF_COMPARE_ONE_FLAG) |
                  (paddr == `LETMR_OFF_REPEAT_ZERO_FLAG)  | (paddr == `LETMR_OFF_REPEAT_ONE_FLAG)  |
                  (paddr == `LETMR_OFF_IF)    | (paddr == `LETMR_OFF_IEN);

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Write strobes per register
    wire wr_ctrl  = bus_wr & (paddr == `LETMR_OFF_CTRL);
    wire wr_cmd   = bus_wr & (paddr == `LETMR_OFF_CMD);
    wire wr_compare_zero_flag = bus_wr & (paddr == `LETMR_OFF_COMPARE_ZERO_FLAG);
    wire wr_compare_one_flag = bus_wr & (paddr == `LETMR_OFF_COMPARE_ONE_FLAG);
    wire wr_repeat_zero_flag  = bus_wr & (paddr == `LETMR_OFF_REPEAT_ZERO_FLAG);
    wire wr_repeat_one_flag  = bus_wr & (paddr == `LETMR_OFF_REPEAT_ONE_FLAG);
    wire wr_if    = bus_wr & (paddr == `LETMR_OFF_IF);
    wire wr_ien   = bus_wr & (paddr == `LETMR_OFF_IEN);

    // Commands; stop beats start when both bits are written together
    wire cmd_start = wr_cmd & pwdata[`LETMR_CMD_START];
    wire cmd_stop  = wr_cmd & pwdata[`LETMR_CMD_STOP];
    wire cmd_clear = wr_cmd & pwdata[`LETMR_CMD_CLEAR];

    // Run condition of the selected repeat mode
    reg run_cond;
    always @* begin
        case (repeat_mode_sel)
            `LETMR_RM_FREE:     run_cond = 1'b1;
            `LETMR_RM_ONESHOT:  run_cond = (repeat_count_zero != `LETMR_RST_REP);
            `LETMR_RM_BUFFERED: run_cond = (repeat_count_zero != `LETMR_RST_REP);
            `LETMR_RM_DOUBLE:   run_cond = (repeat_count_zero != `LETMR_RST_REP) |
                                           (repeat_count_one != `LETMR_RST_REP);
            default:            run_cond = 1'b0;
        endcase
    end

    // One tick per clock while running; underflow when leaving zero
    wire tick      = running & run_cond;
    wire underflow = tick & (timer_counter_value == `LETMR_RST_CNT);
    wire rep_mode  = (repeat_mode_sel != `LETMR_RM_FREE);

    // Repeat zero about to reach zero on this underflow
    wire repeat_zero_flag_last = underflow & rep_mode & (repeat_count_zero == 8'h01);

    // Buffered repeat reload from repeat one
    wire repeat_zero_flag_reload = repeat_zero_flag_last & mode_buffered & repeat_one_flag_written;

    // Repeat counters decrement only in modes that use them
    wire repeat_zero_flag_dec = underflow & rep_mode;
    wire repeat_one_flag_dec = underflow & mode_double;

    // Repeat zero counter; software writes win over hardware updates
    letmr_repeat_counter u_repeat_zero_flag (
        .clock   (clock),
        .srst    (srst),
        .sw_wr   (wr_repeat_zero_flag),
        .sw_data (pwdata[`LETMR_RW-1:0]),
        .hw_load (repeat_zero_flag_reload),
        .hw_data (repeat_count_one),
        .hw_dec  (repeat_zero_flag_dec),
        .value   (repeat_count_zero)
    );

    // Repeat one counter; never reloaded by hardware
    letmr_repeat_counter u_repeat_one_flag (
        .clock   (clock),
        .srst    (srst),
        .sw_wr   (wr_repeat_one_flag),
        .sw_data (pwdata[`LETMR_RW-1:0]),
        .hw_load (1'b0),
        .hw_data (`LETMR_RST_REP),
        .hw_dec  (repeat_one_flag_dec),
        .value   (repeat_count_one)
    );

    // Remember an unconsumed write to repeat one for buffered reload
    always @(posedge clock) begin
        if (srst) begin
            repeat_one_flag_written <= 1'b0;
        end else if (wr_repeat_one_flag) begin
            repeat_one_flag_written <= 1'b1;
        end else if (repeat_zero_flag_reload) begin
            repeat_one_flag_written <= 1'b0;
        end
    end

    // Next running state; stop beats start, a failed run condition drops it
    // A start in a mode whose condition is already false lasts one cycle
    reg next_running;
    always @* begin
        next_running = running;
        if (cmd_stop) begin
            next_running = 1'b0;
        end else if (cmd_start) begin
            next_running = 1'b1;
        end else if (running && !run_cond) begin
            next_running = 1'b0;
        end
    end

    // Running register
    always @(posedge clock) begin
        if (srst) begin
            running <= 1'b0;
        end else begin
            running <= next_running;
        end
    end

    // Next counter value; top is compare zero or all ones
    // A clear command wins over a coincident reload or tick
    reg [`LETMR_CW-1:0] next_cnt;
    always @* begin
        next_cnt = timer_counter_value;
        if (cmd_clear) begin
            next_cnt = `LETMR_RST_CNT;
        end else if (underflow) begin
            if (compare_as_top_en) begin
                next_cnt = compare_reg_zero;
            end else begin
                next_cnt = `LETMR_WRAP_TOP;
            end
        end else if (tick) begin
            next_cnt = timer_counter_value - 16'h0001;
        end
    end

    // Counter register; held while stopped
    always @(posedge clock) begin
        if (srst) begin
            timer_counter_value <= `LETMR_RST_CNT;
        end else begin
            timer_counter_value <= next_cnt;
        end
    end

    // Buffered top load, dropped when software writes compare zero
    wire buf_load = buffered_top_en & repeat_zero_flag_last;

    // Compare zero; a software write beats a coincident buffer load
    always @(posedge clock) begin
        if (srst) begin
            compare_reg_zero <= `LETMR_RST_COMP;
        end else if (wr_compare_zero_flag) begin
            compare_reg_zero <= pwdata[`LETMR_CW-1:0];
        end else if (buf_load) begin
            compare_reg_zero <= compare_reg_one;
        end
    end

    // Compare one, the buffer for compare zero
    always @(posedge clock) begin
        if (srst) begin
            compare_reg_one <= `LETMR_RST_COMP;
        end else if (wr_compare_one_flag) begin
            compare_reg_one <= pwdata[`LETMR_CW-1:0];
        end
    end

    // Control register; new fields act from the next edge
    always @(posedge clock) begin
        if (srst) begin
            timer_control <= 4'h0;
        end else if (wr_ctrl) begin
            timer_control <= pwdata[3:0];
        end
    end

    // Interrupt enables, one per flag
    always @(posedge clock) begin
        if (srst) begin
            irq_enable <= 5'h00;
        end else if (wr_ien) begin
            irq_enable <= pwdata[`LETMR_NFLAGS-1:0];
        end
    end

    // Flag events; counter change compared against compares
    // A compare write alone never raises its flag; only counter moves do
    wire cnt_moved = tick | cmd_clear;
    wire [`LETMR_NFLAGS-1:0] flag_set;
    assign flag_set[`LETMR_IF_COMPARE_ZERO_FLAG] = cnt_moved &
                                       (next_cnt == compare_reg_zero);
    assign flag_set[`LETMR_IF_COMPARE_ONE_FLAG] = cnt_moved &
                                       (next_cnt == compare_reg_one);
    assign flag_set[`LETMR_IF_UF]    = underflow;
    // A software repeat write on the same edge suppresses its flag
    assign flag_set[`LETMR_IF_REPEAT_ZERO_FLAG]  = repeat_zero_flag_last & ~wr_repeat_zero_flag;
    assign flag_set[`LETMR_IF_REPEAT_ONE_FLAG]  = repeat_one_flag_dec & ~wr_repeat_one_flag &
                                       (repeat_count_one == 8'h01);

    // Write-one-to-clear strobes, one per flag
    wire [`LETMR_NFLAGS-1:0] flag_clr = {`LETMR_NFLAGS{wr_if}} & pwdata[`LETMR_NFLAGS-1:0];

    // Sticky flags, cleared by writing one
    genvar gi;
    generate
        for (gi = 0; gi < `LETMR_NFLAGS; gi = gi + 1) begin : g_flag
            letmr_sticky_flag u_flag (
                .clock     (clock),
                .srst      (srst),
                .set_pulse (flag_set[gi]),
                .clr_pulse (flag_clr[gi]),
                .flag      (timer_irq_flags[gi])
            );
        end
    endgenerate

    // Level interrupt while any enabled flag is set
    assign irq         = |(timer_irq_flags & irq_enable);
    assign running_out = running;

    // Read mux; command, unmapped and misaligned offsets read as zero
    reg [31:0] rd_word;
    always @* begin
        case (paddr)
            `LETMR_OFF_CTRL:   rd_word = {28'h0000000, timer_control};
            `LETMR_OFF_STATUS: rd_word = {31'h00000000, running};
            `LETMR_OFF_CNT:    rd_word = {16'h0000, timer_counter_value};
            `LETMR_OFF_COMPARE_ZERO_FLAG:  rd_word = {16'h0000, compare_reg_zero};
            `LETMR_OFF_COMPARE_ONE_FLAG:  rd_word = {16'h0000, compare_reg_one};
            `LETMR_OFF_REPEAT_ZERO_FLAG:   rd_word = {24'h000000, repeat_count_zero};
            `LETMR_OFF_REPEAT_ONE_FLAG:   rd_word = {24'h000000, repeat_count_one};
            `LETMR_OFF_IF:     rd_word = {27'h0000000, timer_irq_flags};
            `LETMR_OFF_IEN:    rd_word = {27'h0000000, irq_enable};
            default:           rd_word = 32'h00000000;
        endcase
    end

    // Read data captured in the setup cycle, stable through access
    always @(posedge clock) begin
        if (srst) begin
            prdata <= 32'h00000000;
        end else if (bus_rd) begin
            prdata <= rd_word;
        end
    end

endmodule

`default_nettype wire

// [letmr_timer_checker.sv]
`timescale 1ns/10ps
`default_nettype none

module letmr_timer_checker (
    // Clock and reset
    input wire logic        clock,
    input wire logic        srst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Interrupt and status
    input wire logic        irq,
    input wire logic        running_out
);
    // Bus decode for the watched cases
    wire acc    = psel && penable;
    wire cmd_wr = acc && pwrite && paddr == 8'h04;
    logic [1:0] mode;
    logic [4:0] ien;

    // Shadow of mode and enables, moved only by bus writes
    always @(posedge clock) begin
        if (srst) begin
            mode <= 2'h0;
            ien  <= 5'h00;
        end else if (acc && pwrite && paddr == 8'h00) begin
            mode <= pwdata[3:2];
        end else if (acc && pwrite && paddr == 8'h24) begin
            ien <= pwdata[4:0];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_stop_wins: assert property (cmd_wr && pwdata[1] |=> !running_out)
        else $error("stop command left timer running");
    a_start_runs: assert property (cmd_wr && pwdata[0] && !pwdata[1] |=> running_out)
        else $error("start command did not set running");
    a_free_keeps: assert property (running_out && mode == 2'h0 && !(cmd_wr && pwdata[1])
        |=> running_out)
        else $error("free mode stopped without stop command");
    a_idle_held: assert property (!running_out && !(cmd_wr && pwdata[0])
        |=> !running_out)
        else $error("timer started without start command");
    a_irq_masked: assert property (ien == 5'h00 |-> !irq)
        else $error("interrupt high with all enables off");
    a_ready_high: assert property (pready)
        else $error("ready low");
    a_err_access: assert property (pslverr |-> acc)
        else $error("error response outside access cycle");
    a_hole_err: assert property (acc && paddr > 8'h27 |-> pslverr && $stable(paddr))
        else $error("unmapped access without error response");
    a_hole_zero: assert property (acc && !pwrite && (paddr > 8'h27 || paddr == 8'h04)
        |-> prdata == 32'h0)
        else $error("unmapped or command read not zero");
endmodule

bind letmr_timer letmr_timer_checker u_letmr_timer_checker (
    .clock      (clock),
    .srst       (srst),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .pready     (pready),
    .prdata     (prdata),
    .pslverr    (pslverr),
    .irq        (irq),
    .running_out(running_out)
);

`default_nettype wire

// [letmr_timer_tb.sv]
`timescale 1ns/10ps
`default_nettype none

module letmr_timer_tb;
    logic        clock   = 1'b0;
    logic        srst    = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    wire         pready;
    wire  [31:0] prdata;
    wire         pslverr;
    wire         irq;
    wire         running_out;
    int          fail_count = 0;
    int          checks     = 0;
    int          cycles     = 0;
    logic [31:0] rd;
    logic        err;

    letmr_timer u_letmr_timer (
        .clock      (clock),
        .srst       (srst),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .pready     (pready),
        .prdata     (prdata),
        .pslverr    (pslverr),
        .irq        (irq),
        .running_out(running_out)
    );

    // 50 MHz clock
    always #10 clock = ~clock;

    task automatic close_out();
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Ceiling far above the few hundred cycles the run needs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; holds the request until pready is seen high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask

    // Bounded wait for the timer to stop by itself
    task automatic wait_idle();
        int n;
        n = 0;
        @(negedge clock);
        while (running_out !== 1'b0 && n < 200) begin
            @(negedge clock);
            n++;
        end
        chk("running", {31'h0, running_out}, 32'h0);
    endtask

    // Counter cleared, stale flags dropped, then started
    task automatic launch(input logic [31:0] ctrl);
        bus(1'b1, 8'h00, ctrl);
        bus(1'b1, 8'h04, 32'h4);
        bus(1'b1, 8'h20, 32'h1F);
        bus(1'b1, 8'h04, 32'h1);
    endtask

    task automatic t_reset();
        for (logic [7:0] a = 8'h00; a <= 8'h24; a += 8'h04) begin
            rchk("reset reg", a, 32'h0);
        end
        chk("irq", {31'h0, irq}, 32'h0);
        bus(1'b1, 8'h28, 32'hFFFFFFFF);
        chk("wr err", {31'h0, err}, 32'h1);
        bus(1'b0, 8'h28, 32'h0);
        chk("rd err", {31'h0, err}, 32'h1);
        chk("hole", rd, 32'h0);
    endtask

    task automatic t_free();
        launch(32'h0);
        rchk("wrap", 8'h0C, 32'hFFFF);
        rchk("tick", 8'h0C, 32'hFFFC);
        rchk("uf", 8'h20, 32'h4);
        chk("free", {31'h0, running_out}, 32'h1);
        rchk("status", 8'h08, 32'h1);
        bus(1'b1, 8'h04, 32'h3);
        rchk("stopped", 8'h0C, 32'hFFF1);
        rchk("held", 8'h0C, 32'hFFF1);
    endtask

    task automatic t_oneshot();
        bus(1'b1, 8'h10, 32'h3);
        bus(1'b1, 8'h18, 32'h2);
        launch(32'h5);
        wait_idle();
        rchk("repeat_zero_flag", 8'h18, 32'h0);
        rchk("top", 8'h0C, 32'h3);
        rchk("flags", 8'h20, 32'hF);
        bus(1'b1, 8'h24, 32'h8);
        @(negedge clock);
        chk("irq on", {31'h0, irq}, 32'h1);
        bus(1'b1, 8'h24, 32'h0);
        @(negedge clock);
        chk("irq mask", {31'h0, irq}, 32'h0);
        bus(1'b1, 8'h24, 32'h8);
        bus(1'b1, 8'h20, 32'h8);
        @(negedge clock);
        chk("irq clr", {31'h0, irq}, 32'h0);
        rchk("flags clr", 8'h20, 32'h7);
    endtask

    task automatic t_buffered();
        bus(1'b1, 8'h10, 32'h2);
        bus(1'b1, 8'h14, 32'h4);
        bus(1'b1, 8'h18, 32'h1);
        bus(1'b1, 8'h1C, 32'h2);
        launch(32'hB);
        wait_idle();
        rchk("buf top", 8'h10, 32'h4);
        rchk("repeat_zero_flag", 8'h18, 32'h0);
        rchk("flags", 8'h20, 32'hF);
    endtask

    task automatic t_double();
        bus(1'b1, 8'h10, 32'h1);
        bus(1'b1, 8'h18, 32'h1);
        bus(1'b1, 8'h1C, 32'h3);
        launch(32'hD);
        wait_idle();
        rchk("repeat_zero_flag", 8'h18, 32'h0);
        rchk("repeat_one_flag", 8'h1C, 32'h0);
        rchk("flags", 8'h20, 32'h1D);
    endtask

    // Compare zero write on the buffer-load edge, then a repeat write mid-run
    task automatic t_rules();
        int n;
        bus(1'b1, 8'h10, 32'h2);
        bus(1'b1, 8'h18, 32'h1);
        launch(32'h5);
        wait_idle();
        bus(1'b1, 8'h00, 32'h7);
        bus(1'b1, 8'h14, 32'h9);
        bus(1'b1, 8'h18, 32'h1);
        bus(1'b1, 8'h04, 32'h1);
        bus(1'b1, 8'h10, 32'h6);
        rchk("compare_zero_flag prio", 8'h10, 32'h6);
        bus(1'b1, 8'h18, 32'h2);
        bus(1'b1, 8'h04, 32'h5);
        bus(1'b1, 8'h18, 32'h3);
        n = 0;
        @(negedge clock);
        while (running_out === 1'b1 && n < 200) begin
            n++;
            @(negedge clock);
        end
        chk("repeat_zero_flag rewrite", {31'h0, n >= 20}, 32'h1);
        chk("repeat_zero_flag done", {31'h0, running_out}, 32'h0);
    endtask

    // Reset for 20 cycles, then each scenario in turn
    initial begin
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        t_reset();
        t_free();
        t_oneshot();
        t_buffered();
        t_double();
        t_rules();
        close_out();
    end
endmodule

`default_nettype wire
